// file: rtl/spmbc_top.v
// Behaviour
// - A shared pin is driven when any sharing peripheral enables output.
// - With several enables, the highest fixed-priority peripheral supplies the value.
// - Sampled pin level goes to every sharing peripheral together, any direction.
// - SPI port zero beats I2C on its four shared pins.
// - Audio port zero first, audio port one or two second, SPI one last.
// - Two capture registers latch eight and five pin levels at external reset release.
// - Only external reset reloads captures; soft resets leave them unchanged.
// - Capture zero bit order follows the SPI zero, I2C and SPI one pins.
// - Capture one: select, enable, frame syncs, data pin; bits 5 to 3 reserved.
// - SPI zero and I2C pin group supports its three sharing options.
// - SPI one mode limits how many data pins audio ports may use.
// - SPI one four-pin modes free the unused select or enable pin for audio.
// - Execution starts from internal ROM at address zero after reset.
// - Capture source select holds two three-bit fields, codes 0 to 4 valid.
`timescale 1ns/1ps
`include "spmbc_regs.vh"

module spmbc_top (
  // Clock and reset.
  input wire ref_clk,
  input wire nrst,
  input wire soft_rst,
  // Register port.
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // First priority peripheral outputs.
  input wire [16:0] pri1_out,
  input wire [16:0] pri1_oe,
  // Second priority peripheral outputs.
  input wire [16:0] pri2_out,
  input wire [16:0] pri2_oe,
  // Third priority outputs, SPI one data pins only.
  input wire [1:0] pri3_out,
  input wire [1:0] pri3_oe,
  // Shared pads.
  input wire [16:0] pad_in,
  output reg [16:0] pad_out,
  output reg [16:0] pad_oe,
  // Unshared boot pads.
  input wire [3:0] aux_in,
  // Peripheral inputs.
  output wire [16:0] periph_in,
  output wire [3:0] aux_periph_in,
  // Configuration outputs.
  output wire [2:0] capture_select_field,
  output wire [2:0] capsel1,
  output wire [3:0] mute_sel0,
  output wire [3:0] mute_sel1,
  output wire [3:0] mute_sel2,
  output wire bridge_rst,
  output reg [31:0] boot_addr
);

  reg [16:0] pad_meta_q;
  reg [16:0] pad_sync_q;
  reg [3:0] aux_meta_q;
  reg [3:0] aux_sync_q;
  reg [1:0] cap_wait_q;
  reg cap_pend_q;
  reg [7:0] cap0_q;
  reg [7:0] cap1_q;
  reg [2:0] csel0_q;
  reg [2:0] csel1_q;
  reg [3:0] mute0_q;
  reg [3:0] mute1_q;
  reg [3:0] mute2_q;
  reg brdg_q;
  reg [31:0] rdata_d;
  wire [16:0] pri3_out_w;
  wire [16:0] pri3_oe_w;

  // Third priority exists only on the two SPI one data pins.
  assign pri3_out_w = {8'h00, pri3_out, 7'h00};
  assign pri3_oe_w = {8'h00, pri3_oe, 7'h00};

  // Per-pin merge of direction and value; first and second priority may own any pin, third only pins 7 and 8.
  genvar gi;
  generate
    for (gi = 0; gi < `SPMBC_NPIN; gi = gi + 1) begin : g_pin
      always @* begin
        pad_oe[gi] = pri1_oe[gi] | pri2_oe[gi] | pri3_oe_w[gi];
        if (pri1_oe[gi]) begin
          pad_out[gi] = pri1_out[gi];
        end else if (pri2_oe[gi]) begin
          pad_out[gi] = pri2_out[gi];
        end else begin
          pad_out[gi] = pri3_out_w[gi];
        end
      end
    end
  endgenerate

  // Pad inputs pass two flops, then fan out to all sharers at once.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pad_meta_q <= 17'h00000;
      pad_sync_q <= 17'h00000;
      aux_meta_q <= 4'h0;
      aux_sync_q <= 4'h0;
    end else begin
      pad_meta_q <= pad_in;
      pad_sync_q <= pad_meta_q;
      aux_meta_q <= aux_in;
      aux_sync_q <= aux_meta_q;
    end
  end

  assign periph_in = pad_sync_q;
  assign aux_periph_in = aux_sync_q;

  // Boot capture runs once after external reset release, once sync is filled.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_pend_q <= 1'b1;
      cap_wait_q <= 2'h0;
      cap0_q <= `SPMBC_CAP_RST;
      cap1_q <= `SPMBC_CAP_RST;
    end else if (cap_pend_q) begin
      if (cap_wait_q == `SPMBC_CAP_WAIT) begin
        cap_pend_q <= 1'b0;
        cap0_q <= {pad_sync_q[`SPMBC_PIN_S0DO], aux_sync_q[`SPMBC_AUX_S0DI],
                   pad_sync_q[`SPMBC_PIN_S0CK], pad_sync_q[`SPMBC_PIN_S0SEL],
                   pad_sync_q[`SPMBC_PIN_S0ENA], pad_sync_q[`SPMBC_PIN_S1DO],
                   pad_sync_q[`SPMBC_PIN_S1DI], pad_sync_q[`SPMBC_PIN_S1CK]};
        cap1_q <= {pad_sync_q[`SPMBC_PIN_S1SEL], pad_sync_q[`SPMBC_PIN_S1ENA],
                   3'h0, aux_sync_q[`SPMBC_AUX_TXFS],
                   aux_sync_q[`SPMBC_AUX_RXFS], aux_sync_q[`SPMBC_AUX_AD0]};
      end else begin
        cap_wait_q <= cap_wait_q + 2'h1;
      end
    end
  end

  // Writable configuration; soft reset clears these but never the captures.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csel0_q <= `SPMBC_CSEL_RST;
      csel1_q <= `SPMBC_CSEL_RST;
      mute0_q <= `SPMBC_MUTE_RST;
      mute1_q <= `SPMBC_MUTE_RST;
      mute2_q <= `SPMBC_MUTE_RST;
      brdg_q <= `SPMBC_BRDG_RST;
    end else if (soft_rst) begin
      csel0_q <= `SPMBC_CSEL_RST;
      csel1_q <= `SPMBC_CSEL_RST;
      mute0_q <= `SPMBC_MUTE_RST;
      mute1_q <= `SPMBC_MUTE_RST;
      mute2_q <= `SPMBC_MUTE_RST;
      brdg_q <= `SPMBC_BRDG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SPMBC_ADDR_CSEL: begin
          csel0_q <= reg_wdata[`SPMBC_CSEL0_HI:`SPMBC_CSEL0_LO];
          csel1_q <= reg_wdata[`SPMBC_CSEL1_HI:`SPMBC_CSEL1_LO];
        end
        `SPMBC_ADDR_MUTE0: begin
          mute0_q <= reg_wdata[`SPMBC_MUTE_HI:`SPMBC_MUTE_LO];
        end
        `SPMBC_ADDR_MUTE1: begin
          mute1_q <= reg_wdata[`SPMBC_MUTE_HI:`SPMBC_MUTE_LO];
        end
        `SPMBC_ADDR_MUTE2: begin
          mute2_q <= reg_wdata[`SPMBC_MUTE_HI:`SPMBC_MUTE_LO];
        end
        `SPMBC_ADDR_BRDG: begin
          brdg_q <= reg_wdata[`SPMBC_BRDG_BIT];
        end
        default: begin
          brdg_q <= brdg_q;
        end
      endcase
    end
  end

  assign capture_select_field = csel0_q;
  assign capsel1 = csel1_q;
  assign mute_sel0 = mute0_q;
  assign mute_sel1 = mute1_q;
  assign mute_sel2 = mute2_q;
  assign bridge_rst = brdg_q;

  // Read mux; reserved and unmapped words read as zero.
  always @* begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `SPMBC_ADDR_CAP0: begin
          rdata_d = {24'h000000, cap0_q};
        end
        `SPMBC_ADDR_CAP1: begin
          rdata_d = {24'h000000, cap1_q};
        end
        `SPMBC_ADDR_CSEL: begin
          rdata_d = {25'h0000000, csel1_q, 1'b0, csel0_q};
        end
        `SPMBC_ADDR_MUTE0: begin
          rdata_d = {28'h0000000, mute0_q};
        end
        `SPMBC_ADDR_MUTE1: begin
          rdata_d = {28'h0000000, mute1_q};
        end
        `SPMBC_ADDR_MUTE2: begin
          rdata_d = {28'h0000000, mute2_q};
        end
        `SPMBC_ADDR_BRDG: begin
          rdata_d = {31'h00000000, brdg_q};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
      boot_addr <= `SPMBC_BOOT_ADDR;
    end else begin
      reg_rdata <= rdata_d;
      boot_addr <= `SPMBC_BOOT_ADDR;
    end
  end

endmodule // spmbc_top

// file: rtl/spmbc_regs.vh
`ifndef SPMBC_REGS_VH
`define SPMBC_REGS_VH

// Register byte addresses.
`define SPMBC_ADDR_CAP0 32'h40000000
`define SPMBC_ADDR_CAP1 32'h40000004
`define SPMBC_ADDR_RSVA 32'h40000008
`define SPMBC_ADDR_RSVB 32'h4000000C
`define SPMBC_ADDR_RSVC 32'h40000010
`define SPMBC_ADDR_CSEL 32'h40000014
`define SPMBC_ADDR_MUTE0 32'h40000018
`define SPMBC_ADDR_MUTE1 32'h4000001C
`define SPMBC_ADDR_MUTE2 32'h40000020
`define SPMBC_ADDR_BRDG 32'h40000024

// Capture source select fields.
`define SPMBC_CSEL1_HI 6
`define SPMBC_CSEL1_LO 4
`define SPMBC_CSEL0_HI 2
`define SPMBC_CSEL0_LO 0
`define SPMBC_CSEL_RST 3'h0
`define SPMBC_CSEL_MAX 3'h4

// Mute input select field.
`define SPMBC_MUTE_HI 3
`define SPMBC_MUTE_LO 0
`define SPMBC_MUTE_RST 4'h0

// Bridge reset control bit.
`define SPMBC_BRDG_BIT 0
`define SPMBC_BRDG_RST 1'b0

// Capture registers.
`define SPMBC_CAP_RST 8'h00
`define SPMBC_CAP_WAIT 2'h2

// Boot start address.
`define SPMBC_BOOT_ADDR 32'h00000000

// Shared pin indices.
`define SPMBC_NPIN 17
`define SPMBC_PIN_S0DO 0
`define SPMBC_PIN_S0CK 1
`define SPMBC_PIN_S0SEL 2
`define SPMBC_PIN_S0ENA 3
`define SPMBC_PIN_S1SEL 4
`define SPMBC_PIN_S1ENA 5
`define SPMBC_PIN_S1CK 6
`define SPMBC_PIN_S1DO 7
`define SPMBC_PIN_S1DI 8

// Unshared pin indices.
`define SPMBC_NAUX 4
`define SPMBC_AUX_S0DI 0
`define SPMBC_AUX_TXFS 1
`define SPMBC_AUX_RXFS 2
`define SPMBC_AUX_AD0 3

`endif

// file: sim/spmbc_periph_model.sv
`timescale 1ns/1ps
module spmbc_periph_model (
  // Clock.
  input wire ref_clk,
  // Bench control.
  input wire [1:0] mode,
  input wire [16:0] val,
  // Peripheral outputs.
  output reg [16:0] pri1_out,
  output reg [16:0] pri1_oe,
  output reg [16:0] pri2_out,
  output reg [16:0] pri2_oe,
  output reg [1:0] pri3_out,
  output reg [1:0] pri3_oe
);
  // Pins get several drivers only in the modes that test arbitration.
  always @(posedge ref_clk) begin
    pri1_out <= val;
    pri2_out <= ~val;
    pri3_out <= val[8:7];
    pri1_oe <= {17{mode == 2'h1}};
    pri2_oe <= {17{mode[1] ^ mode[0]}};
    pri3_oe <= {2{mode != 2'h0}};
  end
endmodule // spmbc_periph_model

// file: sim/spmbc_asserts.sv
`timescale 1ns/1ps
`include "spmbc_regs.vh"
module spmbc_asserts (
  // Clock and reset.
  input wire ref_clk,
  input wire nrst,
  input wire soft_rst,
  // Register port.
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Peripheral side.
  input wire [16:0] pri1_out,
  input wire [16:0] pri1_oe,
  input wire [16:0] pri2_out,
  input wire [16:0] pri2_oe,
  input wire [1:0] pri3_out,
  input wire [1:0] pri3_oe,
  // Pads and outputs.
  input wire [16:0] pad_in,
  input wire [16:0] pad_out,
  input wire [16:0] pad_oe,
  input wire [16:0] periph_in,
  input wire [2:0] capture_select_field,
  input wire [2:0] capsel1,
  input wire [31:0] boot_addr
);
  wire [16:0] p3_oe = {8'h00, pri3_oe, 7'h00};
  wire [16:0] p3_out = {8'h00, pri3_out, 7'h00};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  oe_merge_a: assert property (pad_oe == (pri1_oe | pri2_oe | p3_oe))
    else $error("pad enable merge wrong");
  first_wins_a: assert property (((pad_out ^ pri1_out) & pri1_oe) == 17'h0)
    else $error("first priority value lost");
  second_wins_a: assert property (((pad_out ^ pri2_out) & pri2_oe & ~pri1_oe) == 17'h0)
    else $error("second priority value lost");
  third_wins_a: assert property (((pad_out ^ p3_out) & p3_oe & ~pri1_oe & ~pri2_oe) == 17'h0)
    else $error("third priority value lost");
  fan_out_a: assert property ($stable(pad_in) [*3] |-> periph_in == pad_in)
    else $error("pad level not fanned out");
  rsvd_read_a: assert property (reg_rd && reg_addr == `SPMBC_ADDR_RSVB |=> reg_rdata == 32'h0)
    else $error("reserved location read nonzero");
  cap_upper_a: assert property (reg_rd && reg_addr == `SPMBC_ADDR_CAP1 |=> reg_rdata[31:8] == 24'h0)
    else $error("capture upper bits nonzero");
  csel_write_a: assert property (reg_wr && !soft_rst && reg_addr == `SPMBC_ADDR_CSEL |=>
    {capsel1, capture_select_field} == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])})
    else $error("capture select not updated");
  boot_const_a: assert property (boot_addr == `SPMBC_BOOT_ADDR)
    else $error("boot address wrong");
  cover property (pri1_oe[0] && pri2_oe[0]);
  cover property (reg_rd && reg_addr == `SPMBC_ADDR_CAP1);
  cover property (soft_rst);
endmodule // spmbc_asserts

// file: sim/spmbc_tb_top.sv
`timescale 1ns/1ps
`include "spmbc_regs.vh"
module spmbc_tb_top;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg soft_rst = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [31:0] reg_addr = 32'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg [16:0] pad_in = 17'h000BD;
  reg [3:0] aux_in = 4'hA;
  reg [1:0] mode = 2'h0;
  reg [16:0] val = 17'h0A5C3;
  reg [16:0] eo, ex;
  wire [31:0] reg_rdata, boot_addr;
  wire [16:0] p1o, p1e, p2o, p2e, pad_out, pad_oe, periph_in;
  wire [1:0] p3o, p3e;
  wire [3:0] aux_periph_in;
  wire [2:0] capture_select_field, capsel1;
  wire [3:0] ms0, ms1, ms2;
  wire bridge_rst;
  integer failures = 0;
  integer check_count = 0;
  integer i;
  always #50 ref_clk = ~ref_clk;
  spmbc_periph_model u_peer (.ref_clk(ref_clk), .mode(mode), .val(val), .pri1_out(p1o),
    .pri1_oe(p1e), .pri2_out(p2o), .pri2_oe(p2e), .pri3_out(p3o), .pri3_oe(p3e));
  spmbc_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pri1_out(p1o), .pri1_oe(p1e), .pri2_out(p2o), .pri2_oe(p2e), .pri3_out(p3o),
    .pri3_oe(p3e), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .aux_in(aux_in),
    .periph_in(periph_in), .aux_periph_in(aux_periph_in), .capture_select_field(capture_select_field), .capsel1(capsel1),
    .mute_sel0(ms0), .mute_sel1(ms1), .mute_sel2(ms2), .bridge_rst(bridge_rst),
    .boot_addr(boot_addr));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge ref_clk);
    end
  endtask
  task hard_rst;
    begin
      nrst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge ref_clk);
    end
  endtask
  task results;
    begin
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    hard_rst;
    pad_in <= 17'h1FFFF;
    rd(`SPMBC_ADDR_CAP0, 32'h9C);
    rd(`SPMBC_ADDR_CAP1, 32'hC5);
    wr(`SPMBC_ADDR_CAP0, 32'hFF);
    rd(`SPMBC_ADDR_CAP0, 32'h9C);
    wr(32'h40000028, 32'h5);
    rd(`SPMBC_ADDR_RSVB, 32'h0);
    rd(32'h40000028, 32'h0);
    for (i = 0; i < 5; i = i + 1) begin
      wr(`SPMBC_ADDR_CSEL, i * 17);
      rd(`SPMBC_ADDR_CSEL, i * 17);
      chk({26'h0, capsel1, capture_select_field}, i * 9);
    end
    wr(`SPMBC_ADDR_MUTE0, 32'h5);
    rd(`SPMBC_ADDR_MUTE0, 32'h5);
    wr(`SPMBC_ADDR_MUTE1, 32'hA);
    rd(`SPMBC_ADDR_MUTE1, 32'hA);
    wr(`SPMBC_ADDR_MUTE2, 32'hF);
    rd(`SPMBC_ADDR_MUTE2, 32'hF);
    chk({20'h0, ms2, ms1, ms0}, 32'hFA5);
    wr(`SPMBC_ADDR_BRDG, 32'h1);
    rd(`SPMBC_ADDR_BRDG, 32'h1);
    chk({31'h0, bridge_rst}, 32'h1);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    rd(`SPMBC_ADDR_CAP0, 32'h9C);
    rd(`SPMBC_ADDR_CSEL, 32'h0);
    rd(`SPMBC_ADDR_BRDG, 32'h0);
    for (i = 1; i < 4; i = i + 1) begin
      mode <= i[1:0];
      repeat (2) @(posedge ref_clk);
      eo = (i == 3) ? 17'h00180 : 17'h1FFFF;
      ex = (i == 2) ? ~val : val;
      #1 chk({15'h0, pad_oe}, {15'h0, eo});
      chk({15'h0, pad_out & eo}, {15'h0, ex & eo});
      @(posedge ref_clk);
    end
    pad_in <= 17'h05A5A;
    aux_in <= 4'h3;
    repeat (3) @(posedge ref_clk);
    chk({11'h0, aux_periph_in, periph_in}, {11'h0, 4'h3, 17'h05A5A});
    pad_in <= 17'h0;
    aux_in <= 4'h0;
    hard_rst;
    rd(`SPMBC_ADDR_CAP0, 32'h0);
    rd(`SPMBC_ADDR_CAP1, 32'h0);
    chk(boot_addr, 32'h0);
    results;
  end
  initial begin
    #5000000;
    failures = failures + 1;
    results;
  end
endmodule // spmbc_tb_top
bind spmbc_top spmbc_asserts u_chk (.ref_clk, .nrst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .pri1_out, .pri1_oe, .pri2_out, .pri2_oe, .pri3_out, .pri3_oe, .pad_in,
  .pad_out, .pad_oe, .periph_in, .capture_select_field, .capsel1, .boot_addr);
